// ==== inc/rfcs_pkg.sv ====
// Operation
// - Word at physical 0x016, user word 0x002
// - Power-up fetches word, configures features
// - Word readable always, any protection state
// - Guard/permanence both zero: all writable
// - Permanently unprotected: writable OPEN or SECURED
// - Guarded: air side writable only in SECURED state; serial port always
// - Both set: every write refused
// - Bit 0 enables pointer auto-advance
// - Every accepted write updates protection pair too
// - Multiword enable takes effect after power cycle
// - Block size field gives 2^n words
// - Wrapped flag set by wrap; zero clears
// - Wrap restarts at 0x006; never with auto-protect
`default_nettype none

package rfcs_pkg;
    localparam logic [9:0] PHYS_ADDR = 10'h016;
    localparam logic [9:0] USER_ADDR = 10'h002;
    localparam logic [9:0] WRAP_START = 10'h006;
    localparam int BIT_GUARD = 15;
    localparam int BIT_PERM = 14;
    localparam int BIT_MWE = 7;
    localparam int BSZ_HI = 6;
    localparam int BSZ_LO = 4;
    localparam int BIT_WRAPPED = 3;
    localparam int BIT_WRAP_EN = 2;
    localparam int BIT_AUTO_PROT = 1;
    localparam int BIT_ADV = 0;
    localparam logic [15:0] RESERVED_MASK = 16'h3f00;
    localparam logic [15:0] UNPROG_WORD = 16'h00e0;

    typedef enum logic [1:0] {
        RFCS_LOAD = 2'b01,
        RFCS_RUN = 2'b10
    } rfcs_state_t;
endpackage : rfcs_pkg

`default_nettype wire

// ==== inc/rfcs_guard_if.sv ====
`default_nettype none

interface rfcs_guard_if;
    logic guard;
    logic perm;
    logic from_air;
    logic secured;
    logic accept;

    modport check (
        input guard,
        input perm,
        input from_air,
        input secured,
        output accept
    );
    modport user (
        output guard,
        output perm,
        output from_air,
        output secured,
        input accept
    );
endinterface : rfcs_guard_if

`default_nettype wire

// ==== core/rfcs_guard.sv ====
`default_nettype none

// Decides whether a write may land, from the stored protection pair
module rfcs_guard (
    rfcs_guard_if.check g
);
    always_comb begin
        case ({g.guard, g.perm})
            2'b00: g.accept = 1'b1;
            2'b01: g.accept = 1'b1;
            // Serial port has no access state, so only the air side is held to SECURED
            2'b10: g.accept = !g.from_air || g.secured;
            default: g.accept = 1'b0;
        endcase
    end
endmodule : rfcs_guard

`default_nettype wire

// ==== core/rfcs_csw.sv ====
`default_nettype none

module rfcs_csw (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Power-up fetch from nonvolatile memory
    input wire logic nvm_load_valid,
    input wire logic [15:0] nvm_load_data,
    // Write-through to nonvolatile memory
    output logic nvm_wr_en,
    output logic [15:0] nvm_wr_data,
    // Word access from air side or serial port
    input wire logic req,
    input wire logic req_serial,
    input wire logic req_wr,
    input wire logic [9:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic secured,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [15:0] rsp_rdata,
    // Working pointer events
    input wire logic unaddr_write,
    input wire logic pointer_at_last,
    input wire logic [9:0] working_pointer,
    input wire logic [9:0] check_addr,
    output logic pointer_advance,
    output logic pointer_wrap,
    output logic check_protected,
    // Configuration outputs
    output logic ready,
    output logic multiword_write_enable,
    output logic [2:0] user_block_size,
    output logic [7:0] block_words,
    output logic pointer_wrap_enable,
    output logic auto_protect_enable,
    output logic pointer_auto_advance,
    output logic pointer_wrapped_flag
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [15:0] clean(input logic [15:0] w);
        clean = w & ~rfcs_pkg::RESERVED_MASK;
    endfunction : clean

    function automatic logic [7:0] words_of(input logic [2:0] bsz);
        words_of = 8'(8'h01 << bsz);
    endfunction : words_of

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rfcs_pkg::rfcs_state_t state, next_state;
    logic [15:0] word, next_word;
    logic next_mwe, next_rsp_valid, next_rsp_err, next_nvm_wr_en;
    logic [15:0] next_rsp_rdata, next_nvm_wr_data;
    logic next_advance, next_wrap, next_prot;
    logic hit, run, wrap_evt, wr_ok;

    rfcs_guard_if gif ();

    rfcs_guard u_guard (
        .g(gif.check)
    );

    assign gif.guard = word[rfcs_pkg::BIT_GUARD];
    assign gif.perm = word[rfcs_pkg::BIT_PERM];
    assign gif.from_air = !req_serial;
    assign gif.secured = secured;

    assign run = (state == rfcs_pkg::RFCS_RUN);
    assign hit = req_serial ? (req_addr == rfcs_pkg::PHYS_ADDR) : (req_addr == rfcs_pkg::USER_ADDR);
    assign wr_ok = run && req && hit && req_wr && gif.accept;
    assign wrap_evt = run && unaddr_write && pointer_at_last && word[rfcs_pkg::BIT_WRAP_EN]
        && word[rfcs_pkg::BIT_ADV] && !word[rfcs_pkg::BIT_AUTO_PROT];

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_word = word;
        next_mwe = multiword_write_enable;
        next_rsp_valid = 1'b0;
        next_rsp_err = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_nvm_wr_en = 1'b0;
        next_nvm_wr_data = nvm_wr_data;
        case (state)
            rfcs_pkg::RFCS_LOAD: begin
                if (nvm_load_valid) begin
                    next_word = clean(nvm_load_data);
                    // Only captured here, so later writes need a power cycle
                    next_mwe = nvm_load_data[rfcs_pkg::BIT_MWE];
                    next_state = rfcs_pkg::RFCS_RUN;
                end
            end
            rfcs_pkg::RFCS_RUN: begin
                if (req && hit) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_rdata = word;
                    if (req_wr && !gif.accept) begin
                        next_rsp_err = 1'b1;
                    end
                end
                if (wr_ok) begin
                    // Word lands with reserved bits cleared, protection pair included
                    next_word = clean(req_wdata);
                    // Writes can only clear the wrapped flag
                    next_word[rfcs_pkg::BIT_WRAPPED] = req_wdata[rfcs_pkg::BIT_WRAPPED]
                        && word[rfcs_pkg::BIT_WRAPPED];
                end
                // Set beats a clear in the same cycle
                if (wrap_evt) begin
                    next_word[rfcs_pkg::BIT_WRAPPED] = 1'b1;
                end
                if (wr_ok || wrap_evt) begin
                    next_nvm_wr_en = 1'b1;
                    next_nvm_wr_data = next_word;
                end
            end
            default: next_state = rfcs_pkg::RFCS_LOAD;
        endcase
        next_advance = run && unaddr_write && word[rfcs_pkg::BIT_ADV];
        next_wrap = wrap_evt;
        next_prot = word[rfcs_pkg::BIT_AUTO_PROT] && (check_addr < working_pointer);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= rfcs_pkg::RFCS_LOAD;
            word <= rfcs_pkg::UNPROG_WORD;
            multiword_write_enable <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_rdata <= 16'h0000;
            nvm_wr_en <= 1'b0;
            nvm_wr_data <= 16'h0000;
            pointer_advance <= 1'b0;
            pointer_wrap <= 1'b0;
            check_protected <= 1'b0;
        end else begin
            state <= next_state;
            word <= next_word;
            multiword_write_enable <= next_mwe;
            rsp_valid <= next_rsp_valid;
            rsp_err <= next_rsp_err;
            rsp_rdata <= next_rsp_rdata;
            nvm_wr_en <= next_nvm_wr_en;
            nvm_wr_data <= next_nvm_wr_data;
            pointer_advance <= next_advance;
            pointer_wrap <= next_wrap;
            check_protected <= next_prot;
        end
    end

    // Field views: ready comes from the state flip-flops, block_words from its own register, the rest straight from the word flip-flops
    assign ready = state[1];
    assign user_block_size = word[rfcs_pkg::BSZ_HI:rfcs_pkg::BSZ_LO];
    assign pointer_wrap_enable = word[rfcs_pkg::BIT_WRAP_EN];
    assign auto_protect_enable = word[rfcs_pkg::BIT_AUTO_PROT];
    assign pointer_auto_advance = word[rfcs_pkg::BIT_ADV];
    assign pointer_wrapped_flag = word[rfcs_pkg::BIT_WRAPPED];

    logic [7:0] bw_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bw_q <= 8'h40;
        end else begin
            bw_q <= words_of(next_word[rfcs_pkg::BSZ_HI:rfcs_pkg::BSZ_LO]);
        end
    end
    assign block_words = bw_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_read_any_state: assert property (run && req && hit && !req_wr
        |=> rsp_valid && !rsp_err && rsp_rdata == $past(word))
        else $error("read of control word not answered with stored value");
    a_perm_lock_refuse: assert property (run && req && hit && req_wr
        && word[rfcs_pkg::BIT_GUARD] && word[rfcs_pkg::BIT_PERM]
        |=> rsp_err && word[15:4] == $past(word[15:4]))
        else $error("write accepted while permanently locked");
    a_open_refuse: assert property (run && req && hit && req_wr && !req_serial && !secured
        && word[rfcs_pkg::BIT_GUARD] && !word[rfcs_pkg::BIT_PERM] |=> rsp_err)
        else $error("guarded word written in OPEN state");
    a_unlocked_write: assert property (run && req && hit && req_wr && !word[rfcs_pkg::BIT_GUARD]
        |=> !rsp_err && word[15:14] == $past(req_wdata[15:14])
        && word[7:4] == $past(req_wdata[7:4]))
        else $error("unguarded write not stored");
    a_refused_stable: assert property (rsp_valid && rsp_err |-> $stable(word[15:4]))
        else $error("refused write altered the word");
    a_reserved_zero: assert property ((word & rfcs_pkg::RESERVED_MASK) == 16'h0000)
        else $error("reserved bits not zero");
    a_wrap_sets_flag: assert property (wrap_evt |=> pointer_wrapped_flag && pointer_wrap)
        else $error("wrap did not set flag");
    a_mwe_frozen: assert property (run |=> $stable(multiword_write_enable))
        else $error("multiword enable changed without power cycle");
    a_load_config: assert property (!run && nvm_load_valid
        |=> run ##0 word == clean($past(nvm_load_data)))
        else $error("power-up fetch not applied");
    a_advance_gate: assert property (run && unaddr_write |=> pointer_advance == $past(word[0]))
        else $error("auto-advance not following its enable");
    a_block_words: assert property (##1 block_words == words_of(user_block_size))
        else $error("block words mismatch");

    c_refused_write: cover property (rsp_valid && rsp_err);
    c_accepted_write: cover property (nvm_wr_en && rsp_valid && !rsp_err);
    c_wrap: cover property (pointer_wrap);
    c_secured_write: cover property (run && req && hit && req_wr && secured
        && word[rfcs_pkg::BIT_GUARD] && !word[rfcs_pkg::BIT_PERM]);
endmodule : rfcs_csw

`default_nettype wire

// ==== test/rfcs_reader.sv ====
`default_nettype none

// ----------------------------------------
// Reader issuing word accesses from air side or serial port
// ----------------------------------------
module rfcs_reader (
    // Clock
    input wire logic clock,
    // Request
    output logic req,
    output logic req_serial,
    output logic req_wr,
    output logic [9:0] req_addr,
    output logic [15:0] req_wdata,
    output logic secured,
    // Answer
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic got;
    logic err;
    logic [15:0] rdata;

    initial begin
        req = 1'b0;
        req_serial = 1'b0;
        req_wr = 1'b0;
        req_addr = 10'h000;
        req_wdata = 16'h0000;
        secured = 1'b0;
    end

    // The caller picks the protection pair in d to set the stored state
    task automatic access(input logic ser, input logic wr, input logic sec, input logic [15:0] d);
        @(posedge clock);
        req <= 1'b1;
        req_serial <= ser;
        req_wr <= wr;
        req_addr <= ser ? rfcs_pkg::PHYS_ADDR : rfcs_pkg::USER_ADDR;
        req_wdata <= d;
        secured <= sec;
        @(posedge clock);
        req <= 1'b0;
        // Released data bus does not keep its last value
        req_wdata <= ~d;
        got = 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            #1;
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                err = rsp_err;
                rdata = rsp_rdata;
            end else begin
                @(posedge clock);
            end
        end
    endtask : access
endmodule : rfcs_reader

`default_nettype wire

// ==== test/tb_rfcs_csw.sv ====
`default_nettype none

module tb_rfcs_csw;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic nvm_load_valid, nvm_wr_en, req, req_serial, req_wr, secured, rsp_valid, rsp_err;
    logic [15:0] nvm_load_data, nvm_wr_data, req_wdata, rsp_rdata;
    logic [9:0] req_addr, working_pointer, check_addr;
    logic unaddr_write, pointer_at_last, pointer_advance, pointer_wrap, check_protected, ready;
    logic multiword_write_enable, pointer_wrap_enable, auto_protect_enable;
    logic pointer_auto_advance, pointer_wrapped_flag;
    logic [2:0] user_block_size;
    logic [7:0] block_words;
    int err_total = 0;
    int checks_done = 0;

    always #2.5 clock = ~clock;

    rfcs_csw u_dut (.clock, .arst_n, .nvm_load_valid, .nvm_load_data, .nvm_wr_en, .nvm_wr_data,
        .req, .req_serial, .req_wr, .req_addr, .req_wdata, .secured, .rsp_valid, .rsp_err,
        .rsp_rdata, .unaddr_write, .pointer_at_last, .working_pointer, .check_addr,
        .pointer_advance, .pointer_wrap, .check_protected, .ready, .multiword_write_enable,
        .user_block_size, .block_words, .pointer_wrap_enable, .auto_protect_enable,
        .pointer_auto_advance, .pointer_wrapped_flag);

    rfcs_reader u_rdr (.clock, .req, .req_serial, .req_wr, .req_addr, .req_wdata, .secured,
        .rsp_valid, .rsp_err, .rsp_rdata);

    // ----------------------------------------
    // Checking tasks
    // ----------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Every answer carries the word as it stood before the request
    task automatic acc(input logic ser, input logic wr, input logic sec, input logic [15:0] d,
                       input logic e, input logic [15:0] old);
        u_rdr.access(ser, wr, sec, d);
        cmp({14'h0000, u_rdr.got, u_rdr.err}, {14'h0000, 1'b1, e});
        cmp(u_rdr.rdata, old);
    endtask : acc

    task automatic ptr(input logic [15:0] exp);
        @(posedge clock);
        unaddr_write <= 1'b1;
        @(posedge clock);
        unaddr_write <= 1'b0;
        #1;
        cmp({12'h000, pointer_advance, pointer_wrap, pointer_wrapped_flag, nvm_wr_en}, exp);
    endtask : ptr

    task automatic final_report();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        nvm_load_valid = 1'b0;
        nvm_load_data = 16'h0000;
        unaddr_write = 1'b0;
        pointer_at_last = 1'b1;
        working_pointer = 10'h008;
        check_addr = 10'h005;
        repeat (16) @(posedge clock);
        cmp({4'h0, ready, user_block_size, block_words}, 16'h0640);
        arst_n <= 1'b1;
        @(posedge clock);
        nvm_load_valid <= 1'b1;
        nvm_load_data <= 16'h0095;
        @(posedge clock);
        nvm_load_valid <= 1'b0;
        @(posedge clock);
        #1;
        cmp({6'h00, ready, multiword_write_enable, block_words}, 16'h0302);
        cmp({9'h000, pointer_wrap_enable, auto_protect_enable, pointer_auto_advance,
            pointer_wrapped_flag, user_block_size}, 16'h0051);
        acc(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0095);
        ptr(16'h000f);
        cmp(nvm_wr_data, 16'h009d);
        acc(1'b1, 1'b1, 1'b0, 16'h3f72, 1'b0, 16'h009d);
        acc(1'b1, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0072);
        cmp({6'h00, multiword_write_enable, check_protected, block_words}, 16'h0380);
        ptr(16'h0000);
        acc(1'b0, 1'b1, 1'b0, 16'h8000, 1'b0, 16'h0072);
        acc(1'b0, 1'b1, 1'b0, 16'h8011, 1'b1, 16'h8000);
        acc(1'b0, 1'b1, 1'b1, 16'h8011, 1'b0, 16'h8000);
        acc(1'b0, 1'b1, 1'b1, 16'h4000, 1'b0, 16'h8011);
        acc(1'b0, 1'b1, 1'b0, 16'h4001, 1'b0, 16'h4000);
        acc(1'b0, 1'b1, 1'b1, 16'hc000, 1'b0, 16'h4001);
        acc(1'b1, 1'b1, 1'b1, 16'h0000, 1'b1, 16'hc000);
        acc(1'b0, 1'b1, 1'b1, 16'h0000, 1'b1, 16'hc000);
        acc(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 16'hc000);
        final_report();
    end

    initial begin
        #20000;
        err_total++;
        final_report();
    end
endmodule : tb_rfcs_csw

`default_nettype wire
